// ---- bench/slsir_dev_model.sv ----
// Purpose: Behavioural id slave on the open-drain line
// Assumes: Line resolved by the bench, delays counted on sys_clk
// Notes:   en low means no slave, slow delays the presence pulse
module slsir_dev_model #(
   parameter logic [63:0] ID     = 64'h0,
   parameter int          US_CYC = 40
) (
   input  wire logic  sys_clk,
   input  wire logic  en,
   input  wire logic  slow,
   input  wire logic  line,
   output logic       pull = 1'b0, // Pulls low only
   output logic [7:0] cmd = 8'h00,
   output int         n_cmd = 0,
   output int         n_sent = 0
);
   timeunit 1ns;
   timeprecision 1ps;
   typedef enum logic [2:0] {M_IDLE, M_WAIT, M_PRES, M_CMD, M_READ} slsir_dm_t;
   localparam int RST_CYC = 120 * US_CYC;
   localparam int PDL_CYC = 100 * US_CYC;
   localparam int SMP_CYC = 30 * US_CYC;
   localparam int HLD_CYC = 15 * US_CYC;
   slsir_dm_t st = M_IDLE;
   logic      line_q = 1'b1;
   logic      armed = 1'b0;
   int        low_len = 0;
   int        t = 0;
   int        pdh;

   assign pdh = slow ? 55 * US_CYC : 15 * US_CYC;

   always @(posedge sys_clk) begin
      line_q  <= line;
      low_len <= line ? 0 : low_len + 1;
      t       <= t + 1;
      // Own presence pulse must not restart the delay timer
      if (line_q && !line && !pull) begin
         t     <= 0;
         armed <= 1'b1;
      end
      case (st)
         M_WAIT: if (line && !line_q) begin
            st <= M_PRES;
            t  <= 0;
         end
         M_PRES: begin
            pull <= en && t >= pdh && t < pdh + PDL_CYC;
            if (t == pdh + PDL_CYC) begin
               st    <= en ? M_CMD : M_IDLE;
               armed <= 1'b0;
            end
         end
         M_CMD: if (armed && t == SMP_CYC) begin
            cmd[n_cmd] <= line;
            n_cmd      <= n_cmd + 1;
            armed      <= 1'b0;
            if (n_cmd == 7)
               st <= ({line, cmd[6:0]} inside {8'h33, 8'h0F}) ? M_READ : M_IDLE;
         end
         M_READ: begin
            if (line_q && !line) pull <= !ID[n_sent];
            if (armed && t == HLD_CYC) begin
               pull   <= 1'b0;
               armed  <= 1'b0;
               n_sent <= n_sent + 1;
               if (n_sent == 63) st <= M_IDLE;
            end
         end
         default: pull <= 1'b0;
      endcase
      if (!line && low_len >= RST_CYC) begin
         st     <= M_WAIT;
         pull   <= 1'b0;
         n_cmd  <= 0;
         n_sent <= 0;
      end
   end
endmodule // slsir_dev_model

// ---- bench/slsir_master_chk.sv ----
// Purpose: Port assertions for the serial id master
// Assumes: One clock, synchronous active-low reset
// Notes:   Counters measure line phases
module slsir_master_chk #(
   parameter int US_CYC      = 40,
   parameter int RST_LOW_CYC = 19200,
   parameter int STUCK_CYC   = 4800
) (
   input wire logic        sys_clk,
   input wire logic        resetn,
   input wire logic        start,
   input wire logic        cmd_alt,
   input wire logic        dq_in,
   input wire logic        dq_out,
   input wire logic        dq_oe,
   input wire logic        busy,
   input wire logic        done,
   input wire logic        present,
   input wire logic        id_valid,
   input wire logic        bus_fault,
   input wire logic [7:0]  class_code,
   input wire logic [47:0] serial_num,
   input wire logic [7:0]  crc_code
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LO1_MAX  = 15 * US_CYC;
   localparam int LO0_MIN  = 60 * US_CYC;
   localparam int LO0_MAX  = 120 * US_CYC;
   localparam int RATE_CYC = US_CYC * 6135 / 100;
   // ---------------------------------------------------------------
   // Phase counters
   // ---------------------------------------------------------------
   logic oe_q, oe_next, fp, fp_next, rise, fall, take;
   int   hi, hi_next, lo, lo_next, per, per_next, n, n_next, stk, stk_next;

   always_comb begin
      take     = start && !busy && !done;
      rise     = dq_oe && !oe_q;
      fall     = oe_q && !dq_oe;
      oe_next  = dq_oe;
      fp_next  = take ? 1'b1 : (fall ? 1'b0 : fp);
      hi_next  = dq_oe ? hi + 1 : 0;
      lo_next  = dq_oe ? 0 : lo + 1;
      per_next = rise ? 0 : per + 1;
      n_next   = take ? 0 : (rise ? n + 1 : n);
      stk_next = (!busy && !dq_in) ? stk + 1 : 0;
   end

   always_ff @(posedge sys_clk) begin
      oe_q <= resetn ? oe_next : 1'b0;
      fp   <= resetn ? fp_next : 1'b0;
      hi   <= resetn ? hi_next : 0;
      lo   <= resetn ? lo_next : 0;
      per  <= resetn ? per_next : 0;
      n    <= resetn ? n_next : 0;
      stk  <= resetn ? stk_next : 0;
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   AST_PIN_LOW: assert property (dq_oe |-> dq_out == 1'b0)
      else $error("line driven high");
   AST_START: assert property (take |=> busy ##2 dq_oe)
      else $error("start did not open reset pulse");
   AST_RST_LEN: assert property (fp && fall |-> hi >= RST_LOW_CYC && hi < 2 * RST_LOW_CYC)
      else $error("reset pulse length wrong");
   AST_SLOT_LOW: assert property (!fp && fall |-> (hi >= US_CYC && hi <= LO1_MAX) ||
                                  (hi >= LO0_MIN && hi <= LO0_MAX))
      else $error("slot low time wrong");
   AST_RECOVER: assert property (!fp && rise |-> lo >= US_CYC)
      else $error("recovery too short");
   AST_RATE: assert property (!fp && rise |-> per >= RATE_CYC)
      else $error("slot rate too high");
   AST_COUNT: assert property (done |-> n == (present ? 73 : 1))
      else $error("slot count wrong");
   AST_DONE: assert property (done |-> !busy && $past(busy) ##1 !done)
      else $error("done pulse wrong");
   AST_ID_VALID: assert property ($rose(id_valid) |-> done && present)
      else $error("id valid without read");
   AST_FAULT_SET: assert property (stk == STUCK_CYC + 8 |-> bus_fault)
      else $error("stuck line not flagged");
   AST_FAULT_EARLY: assert property ($rose(bus_fault) |-> stk >= STUCK_CYC)
      else $error("fault flagged early");
endmodule // slsir_master_chk

// ---- bench/tb.sv ----
// Purpose: Self-checking bench for the serial id master
// Assumes: Pull-up on the line, one slave model
// Notes:   Time base scaled to US cycles per microsecond to keep runs short
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int          US     = 4;
   localparam int          STUCK  = 50;
   localparam logic [63:0] DEV_ID = 64'hC312_3456_789A_BC5A; // Value is arbitrary
   logic        sys_clk, resetn, start, cmd_alt, dev_en, dev_slow, hold_low, dev_pull;
   logic        dq_out, dq_oe, busy, done, present, id_valid, bus_fault;
   logic [7:0]  class_code, crc_code, dev_cmd;
   logic [47:0] serial_num;
   int          dev_ncmd, dev_nsent;
   int          fails = 0;
   int          n_checks = 0;
   int          cyc = 0;
   wire         line = (dq_oe ? dq_out : 1'b1) & !dev_pull & !hold_low;

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   slsir_master #(.US_CYC(US), .STUCK_CYC(STUCK)) u_slsir_master (
      .sys_clk(sys_clk), .resetn(resetn), .start(start), .cmd_alt(cmd_alt),
      .dq_in(line), .dq_out(dq_out), .dq_oe(dq_oe), .busy(busy), .done(done),
      .present(present), .id_valid(id_valid), .bus_fault(bus_fault),
      .class_code(class_code), .serial_num(serial_num), .crc_code(crc_code));

   // Single slave on the line
   slsir_dev_model #(.ID(DEV_ID), .US_CYC(US)) u_dev (
      .sys_clk(sys_clk), .en(dev_en), .slow(dev_slow), .line(line), .pull(dev_pull),
      .cmd(dev_cmd), .n_cmd(dev_ncmd), .n_sent(dev_nsent));

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic kick(input logic alt);
      @(negedge sys_clk);
      check(line, 1'b1);
      cmd_alt = alt;
      start = 1'b1;
      @(negedge sys_clk);
      start = 1'b0;
      check(busy, 1'b1);
   endtask

   task automatic wait_done;
      for (int k = 0; k < 40000 && done !== 1'b1; k++) @(negedge sys_clk);
      check(done, 1'b1);
   endtask

   task automatic wait_ncmd(input int v);
      for (int k = 0; k < 20000 && dev_ncmd != v; k++) @(negedge sys_clk);
      check(dev_ncmd, v);
   endtask

   // Stuck line flagged in idle, then a transaction with nobody present
   task automatic t_fault_absent;
      dev_en = 1'b0;
      hold_low = 1'b1;
      repeat (STUCK + 20) @(negedge sys_clk);
      check(bus_fault, 1'b1);
      hold_low = 1'b0;
      repeat (5) @(negedge sys_clk);
      kick(1'b0);
      wait_done();
      check({present, id_valid, bus_fault}, 3'b000);
   endtask

   // Read with either command code; optional abort by reset mid-read
   task automatic t_read(input logic alt, input logic slow, input logic [7:0] exp, input logic full);
      dev_en = 1'b1;
      dev_slow = slow;
      kick(alt);
      wait_ncmd(0);
      wait_ncmd(8);
      check(dev_cmd, exp);
      check(present, 1'b1);
      if (full) begin
         wait_done();
         check({crc_code, serial_num, class_code}, DEV_ID);
         check({present, id_valid}, 2'b11);
         check(dev_nsent, 64);
      end else begin
         repeat (9000) @(negedge sys_clk);
         resetn = 1'b0;
         repeat (4) @(negedge sys_clk);
         resetn = 1'b1;
         @(negedge sys_clk);
         check({busy, done, present, id_valid, dq_oe}, 5'b00000);
      end
   endtask

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 90000) begin
         fails++;
         wrap_up();
      end
   end

   initial begin
      resetn = 1'b0;
      start = 1'b0;
      cmd_alt = 1'b0;
      dev_en = 1'b0;
      dev_slow = 1'b0;
      hold_low = 1'b0;
      repeat (20) @(negedge sys_clk);
      resetn = 1'b1;
      repeat (4) @(negedge sys_clk);
      t_fault_absent();
      t_read(1'b0, 1'b0, 8'h33, 1'b1);
      t_read(1'b1, 1'b1, 8'h0F, 1'b0);
      wrap_up();
   end
endmodule // tb

bind slsir_master slsir_master_chk #(
   .US_CYC(US_CYC), .RST_LOW_CYC(RST_LOW_CYC), .STUCK_CYC(STUCK_CYC)
) u_chk (
   .sys_clk(sys_clk), .resetn(resetn), .start(start), .cmd_alt(cmd_alt),
   .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .busy(busy), .done(done),
   .present(present), .id_valid(id_valid), .bus_fault(bus_fault),
   .class_code(class_code), .serial_num(serial_num), .crc_code(crc_code));

// ---- verilog/slsir_defs.svh ----
// Purpose: Timing, command and size constants for the serial id master
// Assumes: sys_clk at 40 MHz
// Notes:   Cycle counts are derived from the times in microseconds
`ifndef SLSIR_DEFS_SVH
`define SLSIR_DEFS_SVH

// ----------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------
`define SLSIR_CLK_MHZ        40

// ----------------------------------------------------------------------
// Line times in microseconds
// ----------------------------------------------------------------------
`define SLSIR_T_RSTL_US      480
`define SLSIR_T_PRES_SMP_US  70
`define SLSIR_T_RSTH_US      480
`define SLSIR_T_LOW1_US      6
`define SLSIR_T_LOW0_US      60
`define SLSIR_T_RDLOW_US     2
`define SLSIR_T_RDSMP_US     12
`define SLSIR_T_SLOT_US      70
`define SLSIR_T_REC_US       10
`define SLSIR_T_STUCK_US     120

// ----------------------------------------------------------------------
// Commands and sizes
// ----------------------------------------------------------------------
`define SLSIR_CMD_READ_ID    8'h33
`define SLSIR_CMD_READ_ALT   8'h0F
`define SLSIR_CMD_BITS       8
`define SLSIR_ID_BITS        64
`define SLSIR_CLASS_LSB      0
`define SLSIR_CLASS_MSB      7
`define SLSIR_SERIAL_LSB     8
`define SLSIR_SERIAL_MSB     55
`define SLSIR_CRC_LSB        56
`define SLSIR_CRC_MSB        63
`define SLSIR_CNT_W          16

`endif

// ---- verilog/slsir_master.sv ----
// Purpose: Bus master that reads the 64-bit identity of one line slave
// Assumes: External pull-up on the line, one slave present for a read
// Notes:   Start pulse runs reset, then command byte and 64 read slots if presence is seen
`include "slsir_defs.svh"
module slsir_master #(
   parameter int CNT_W       = `SLSIR_CNT_W,
   parameter int US_CYC      = `SLSIR_CLK_MHZ,
   parameter int RST_LOW_CYC = `SLSIR_T_RSTL_US * US_CYC,
   parameter int RST_SMP_CYC = (`SLSIR_T_RSTL_US + `SLSIR_T_PRES_SMP_US) * US_CYC,
   parameter int RST_END_CYC = (`SLSIR_T_RSTL_US + `SLSIR_T_RSTH_US) * US_CYC,
   parameter int STUCK_CYC   = `SLSIR_T_STUCK_US * US_CYC
) (
   input  wire logic         sys_clk,
   input  wire logic         resetn,
   input  wire logic         start,
   input  wire logic         cmd_alt,
   input  wire logic         dq_in,
   output logic              dq_out,
   output logic              dq_oe,
   output logic              busy,
   output logic              done,
   output logic              present,
   output logic              id_valid,
   output logic              bus_fault,
   output logic [7:0]        class_code,
   output logic [47:0]       serial_num,
   output logic [7:0]        crc_code
);
   // -------------------------------------------------------------------
   // Line input synchroniser
   // -------------------------------------------------------------------
   logic dq_s1_reg, dq_s2_reg, dq_s3_reg, line_reg, line_next;

   always_comb begin
      line_next = line_reg;
      if (dq_s2_reg == dq_s3_reg) begin
         line_next = dq_s3_reg;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         dq_s1_reg <= 1'b1;
         dq_s2_reg <= 1'b1;
         dq_s3_reg <= 1'b1;
         line_reg  <= 1'b1;
      end else begin
         dq_s1_reg <= dq_in;
         dq_s2_reg <= dq_s1_reg;
         dq_s3_reg <= dq_s2_reg;
         line_reg  <= line_next;
      end
   end

   // -------------------------------------------------------------------
   // Slot engine
   // -------------------------------------------------------------------
   slsir_slot_if sl ();

   slsir_slot #(
      .CNT_W       (CNT_W),
      .US_CYC      (US_CYC),
      .RST_LOW_CYC (RST_LOW_CYC),
      .RST_SMP_CYC (RST_SMP_CYC),
      .RST_END_CYC (RST_END_CYC)
   ) u_slot (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .sl      (sl.eng)
   );

   // -------------------------------------------------------------------
   // Sequencer
   // -------------------------------------------------------------------
   slsir_pkg::slsir_state_t  state_reg, state_next;
   slsir_pkg::slsir_kind_t   kind_reg, kind_next;
   logic                     go_reg, go_next;
   logic [6:0]               bit_cnt_reg, bit_cnt_next;
   logic [7:0]               cmd_reg, cmd_next;
   logic [63:0]              id_reg, id_next;
   logic                     busy_reg, busy_next;
   logic                     done_reg, done_next;
   logic                     present_reg, present_next;
   logic                     id_valid_reg, id_valid_next;
   logic                     fault_reg, fault_next;
   logic                     oe_reg;
   logic [CNT_W-1:0]         low_cnt_reg, low_cnt_next;

   assign sl.go   = go_reg;
   assign sl.kind = kind_reg;
   assign sl.line = line_reg;

   always_comb begin
      state_next    = state_reg;
      kind_next     = kind_reg;
      go_next       = 1'b0;
      bit_cnt_next  = bit_cnt_reg;
      cmd_next      = cmd_reg;
      id_next       = id_reg;
      busy_next     = busy_reg;
      done_next     = 1'b0;
      present_next  = present_reg;
      id_valid_next = id_valid_reg;
      fault_next    = fault_reg;
      low_cnt_next  = low_cnt_reg;
      case (state_reg)
         slsir_pkg::ST_IDLE: begin
            if (!line_reg) begin
               if (low_cnt_reg == CNT_W'(STUCK_CYC)) begin
                  fault_next = 1'b1;
               end else begin
                  low_cnt_next = low_cnt_reg + 1'b1;
               end
            end else begin
               low_cnt_next = '0;
            end
            if (start) begin
               state_next    = slsir_pkg::ST_RST;
               kind_next     = slsir_pkg::SK_RST;
               go_next       = 1'b1;
               busy_next     = 1'b1;
               present_next  = 1'b0;
               id_valid_next = 1'b0;
               fault_next    = 1'b0;
               low_cnt_next  = '0;
            end
         end
         slsir_pkg::ST_RST: begin
            if (sl.done) begin
               if (!sl.bit_val) begin
                  present_next = 1'b1;
                  state_next   = slsir_pkg::ST_CMD;
                  bit_cnt_next = '0;
                  cmd_next     = cmd_alt ? `SLSIR_CMD_READ_ALT
                                         : `SLSIR_CMD_READ_ID;
               end else begin
                  state_next = slsir_pkg::ST_IDLE;
                  busy_next  = 1'b0;
                  done_next  = 1'b1;
               end
            end
         end
         slsir_pkg::ST_CMD: begin
            if (sl.done) begin
               cmd_next     = {1'b0, cmd_reg[7:1]};
               bit_cnt_next = bit_cnt_reg + 1'b1;
               if (bit_cnt_reg == 7'(`SLSIR_CMD_BITS - 1)) begin
                  state_next   = slsir_pkg::ST_READ;
                  bit_cnt_next = '0;
               end
            end else if (!sl.busy && !go_reg) begin
               go_next   = 1'b1;
               kind_next = cmd_reg[0] ? slsir_pkg::SK_W1
                                      : slsir_pkg::SK_W0;
            end
         end
         slsir_pkg::ST_READ: begin
            if (sl.done) begin
               id_next      = {sl.bit_val, id_reg[63:1]};
               bit_cnt_next = bit_cnt_reg + 1'b1;
               if (bit_cnt_reg == 7'(`SLSIR_ID_BITS - 1)) begin
                  state_next    = slsir_pkg::ST_IDLE;
                  id_valid_next = 1'b1;
                  busy_next     = 1'b0;
                  done_next     = 1'b1;
               end
            end else if (!sl.busy && !go_reg) begin
               go_next   = 1'b1;
               kind_next = slsir_pkg::SK_RD;
            end
         end
         default: begin
            state_next = slsir_pkg::ST_IDLE;
            busy_next  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_reg    <= slsir_pkg::ST_IDLE;
         kind_reg     <= slsir_pkg::SK_RD;
         go_reg       <= 1'b0;
         bit_cnt_reg  <= '0;
         cmd_reg      <= '0;
         id_reg       <= '0;
         busy_reg     <= 1'b0;
         done_reg     <= 1'b0;
         present_reg  <= 1'b0;
         id_valid_reg <= 1'b0;
         fault_reg    <= 1'b0;
         low_cnt_reg  <= '0;
         oe_reg       <= 1'b0;
      end else begin
         state_reg    <= state_next;
         kind_reg     <= kind_next;
         go_reg       <= go_next;
         bit_cnt_reg  <= bit_cnt_next;
         cmd_reg      <= cmd_next;
         id_reg       <= id_next;
         busy_reg     <= busy_next;
         done_reg     <= done_next;
         present_reg  <= present_next;
         id_valid_reg <= id_valid_next;
         fault_reg    <= fault_next;
         low_cnt_reg  <= low_cnt_next;
         oe_reg       <= sl.drive;
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   assign dq_out     = 1'b0;
   assign dq_oe      = oe_reg;
   assign busy       = busy_reg;
   assign done       = done_reg;
   assign present    = present_reg;
   assign id_valid   = id_valid_reg;
   assign bus_fault  = fault_reg;
   assign class_code = id_reg[`SLSIR_CLASS_MSB:`SLSIR_CLASS_LSB];
   assign serial_num = id_reg[`SLSIR_SERIAL_MSB:`SLSIR_SERIAL_LSB];
   assign crc_code   = id_reg[`SLSIR_CRC_MSB:`SLSIR_CRC_LSB];
endmodule // slsir_master

// ---- verilog/slsir_pkg.sv ----
// Purpose: Types shared by the serial id master and its slot engine
// Assumes: Nothing
// Notes:   One-hot codes written out
package slsir_pkg;

   // -------------------------------------------------------------------
   // Slot kinds
   // -------------------------------------------------------------------
   typedef enum logic [3:0] {
      SK_RST = 4'b0001,
      SK_W0  = 4'b0010,
      SK_W1  = 4'b0100,
      SK_RD  = 4'b1000
   } slsir_kind_t;

   // -------------------------------------------------------------------
   // Master states
   // -------------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_RST  = 4'b0010,
      ST_CMD  = 4'b0100,
      ST_READ = 4'b1000
   } slsir_state_t;

endpackage : slsir_pkg

// ---- verilog/slsir_slot.sv ----
// Purpose: Times one reset or bit slot on the line
// Assumes: line is already synchronised
// Notes:   drive high means pull the line low
`include "slsir_defs.svh"
module slsir_slot #(
   parameter int CNT_W       = `SLSIR_CNT_W,
   parameter int US_CYC      = `SLSIR_CLK_MHZ,
   parameter int RST_LOW_CYC = `SLSIR_T_RSTL_US * US_CYC,
   parameter int RST_SMP_CYC = (`SLSIR_T_RSTL_US + `SLSIR_T_PRES_SMP_US) * US_CYC,
   parameter int RST_END_CYC = (`SLSIR_T_RSTL_US + `SLSIR_T_RSTH_US) * US_CYC
) (
   input wire logic    sys_clk,
   input wire logic    resetn,
   slsir_slot_if.eng   sl
);
   // -------------------------------------------------------------------
   // Slot timing
   // -------------------------------------------------------------------
   localparam logic [CNT_W-1:0] LOW0 = CNT_W'(`SLSIR_T_LOW0_US * US_CYC);
   localparam logic [CNT_W-1:0] LOW1 = CNT_W'(`SLSIR_T_LOW1_US * US_CYC);
   localparam logic [CNT_W-1:0] RDLO = CNT_W'(`SLSIR_T_RDLOW_US * US_CYC);
   localparam logic [CNT_W-1:0] RDSM = CNT_W'(`SLSIR_T_RDSMP_US * US_CYC);
   localparam logic [CNT_W-1:0] SEND =
      CNT_W'((`SLSIR_T_SLOT_US + `SLSIR_T_REC_US) * US_CYC);
   localparam logic [CNT_W-1:0] RLOW = CNT_W'(RST_LOW_CYC);
   localparam logic [CNT_W-1:0] RSMP = CNT_W'(RST_SMP_CYC);
   localparam logic [CNT_W-1:0] REND = CNT_W'(RST_END_CYC);

   logic [CNT_W-1:0]        cnt_reg, cnt_next;
   logic                    busy_reg, busy_next;
   logic                    drive_reg, drive_next;
   logic                    bit_reg, bit_next;
   logic                    done_reg, done_next;
   slsir_pkg::slsir_kind_t  kind_reg, kind_next;
   logic [CNT_W-1:0]        low_len, smp_at, end_at;

   always_comb begin
      case (kind_reg)
         slsir_pkg::SK_RST: begin
            low_len = RLOW;
            smp_at  = RSMP;
            end_at  = REND;
         end
         slsir_pkg::SK_W0: begin
            low_len = LOW0;
            smp_at  = RDSM;
            end_at  = SEND;
         end
         slsir_pkg::SK_W1: begin
            low_len = LOW1;
            smp_at  = RDSM;
            end_at  = SEND;
         end
         default: begin
            low_len = RDLO;
            smp_at  = RDSM;
            end_at  = SEND;
         end
      endcase
      cnt_next   = cnt_reg;
      busy_next  = busy_reg;
      drive_next = drive_reg;
      bit_next   = bit_reg;
      kind_next  = kind_reg;
      done_next  = 1'b0;
      if (busy_reg) begin
         cnt_next   = cnt_reg + 1'b1;
         drive_next = (cnt_next < low_len);
         if (cnt_reg == smp_at) begin
            bit_next = sl.line;
         end
         if (cnt_reg == end_at) begin
            busy_next  = 1'b0;
            done_next  = 1'b1;
            drive_next = 1'b0;
         end
      end else if (sl.go) begin
         busy_next  = 1'b1;
         kind_next  = sl.kind;
         cnt_next   = '0;
         drive_next = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         cnt_reg   <= '0;
         busy_reg  <= 1'b0;
         drive_reg <= 1'b0;
         bit_reg   <= 1'b1;
         done_reg  <= 1'b0;
         kind_reg  <= slsir_pkg::SK_RD;
      end else begin
         cnt_reg   <= cnt_next;
         busy_reg  <= busy_next;
         drive_reg <= drive_next;
         bit_reg   <= bit_next;
         done_reg  <= done_next;
         kind_reg  <= kind_next;
      end
   end

   assign sl.busy    = busy_reg;
   assign sl.done    = done_reg;
   assign sl.bit_val = bit_reg;
   assign sl.drive   = drive_reg;
endmodule // slsir_slot

// ---- verilog/slsir_slot_if.sv ----
// Purpose: Link between the master sequencer and its slot engine
// Assumes: Both ends on sys_clk
// Notes:   go is a one-cycle pulse, done a one-cycle pulse
interface slsir_slot_if;
   logic                  go;
   slsir_pkg::slsir_kind_t kind;
   logic                  busy;
   logic                  done;
   logic                  bit_val;
   logic                  drive;
   logic                  line;

   modport ctrl (output go, output kind, output line,
                 input busy, input done, input bit_val, input drive);
   modport eng  (input go, input kind, input line,
                 output busy, output done, output bit_val, output drive);
endinterface : slsir_slot_if
